// ===== deo_deframer_dev.sv
// Purpose: Two deframers with per-lane elastic buffers released on a shifted boundary
// Assumes: Framer honours offset range and the write, SYSREF, restart order
// Notes:   Boundary counter restarts at SYSREF; boundary where it equals the offset
`timescale 1ns/10ps
`default_nettype none
module deo_deframer_dev #(
    parameter int LANES = 2
) (
    // Clock and reset
    input  wire logic                                CLK,
    input  wire logic                                ARST_N,
    // Link
    deo_link_if.dev                                  LINK,
    // Configuration
    input  wire logic                                MODE_C,
    input  wire logic [deo_pkg::NDFR*LANES-1:0]      LANE_EN,
    // Released data and state
    output logic      [deo_pkg::NDFR-1:0]            OUT_VALID,
    output logic      [deo_pkg::NDFR*LANES*8-1:0]    OUT_DATA,
    output logic      [deo_pkg::NDFR*LANES*deo_pkg::PTR_W-1:0] DEPTH,
    output logic      [deo_pkg::NDFR*deo_pkg::OFF_W-1:0] ACTIVE_OFFSET
);
    localparam int NW = deo_pkg::PTR_W - 1;
    localparam logic [NW:0] FILL_MAX = (NW + 1)'(deo_pkg::BUF_OCTETS);

    // Decode: {hit, deframer, high byte}
    function automatic logic [2:0] reg_decode(input logic [15:0] a);
        logic [2:0] r;
        r = 3'h0;
        if (a == deo_pkg::RA_D0_LO || a == deo_pkg::RA_D0_ALO) begin
            r = 3'h4;
        end
        if (a == deo_pkg::RA_D0_HI || a == deo_pkg::RA_D0_AHI) begin
            r = 3'h5;
        end
        if (a == deo_pkg::RA_D1_LO || a == deo_pkg::RA_D1_ALO) begin
            r = 3'h6;
        end
        if (a == deo_pkg::RA_D1_HI || a == deo_pkg::RA_D1_AHI) begin
            r = 3'h7;
        end
        return r;
    endfunction

    wire logic [2:0]  wr_dec = reg_decode(LINK.reg_addr);
    wire logic        wr_hit = wr_dec[2] & LINK.reg_we;
    wire logic [15:0] period = MODE_C ? deo_pkg::PERIOD_C : deo_pkg::PERIOD_B;

    logic [7:0] stage_lo [deo_pkg::NDFR];
    logic [7:0] stage_hi [deo_pkg::NDFR];
    logic [7:0] rdata_ff;
    wire  logic [7:0] rd_mux = wr_dec[0] ? stage_hi[wr_dec[1]] : stage_lo[wr_dec[1]];

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= wr_dec[2] ? rd_mux : 8'h00;
        end
    end
    assign LINK.reg_rdata = rdata_ff;

    genvar d, l;
    generate
        for (d = 0; d < deo_pkg::NDFR; d++) begin : g_dfr
            logic [15:0]      cnt_ff;
            logic [15:0]      act_off_ff;
            logic             pend_ff;
            logic             armed_ff;
            logic             rel_ff;
            logic [LANES-1:0] seen;
            wire  logic       wr_me   = wr_hit & (wr_dec[1] == 1'(d));
            wire  logic [LANES-1:0] en = LANE_EN[d*LANES +: LANES];
            wire  logic       last    = (cnt_ff >= period - 16'h0001);
            wire  logic       bound   = (cnt_ff == act_off_ff);
            wire  logic       all_seen = ((seen | ~en) == {LANES{1'b1}}) & (|en);
            wire  logic [15:0] nxt_off = {stage_hi[d], stage_lo[d]};

            // Staged bytes, either address pair
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    stage_lo[d] <= deo_pkg::OFF_RST;
                    stage_hi[d] <= deo_pkg::OFF_RST;
                end else if (wr_me) begin
                    if (wr_dec[0]) begin
                        stage_hi[d] <= LINK.reg_wdata;
                    end else begin
                        stage_lo[d] <= LINK.reg_wdata;
                    end
                end
            end

            // Write, then SYSREF, then restart applies the offset
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    pend_ff    <= 1'b0;
                    armed_ff   <= 1'b0;
                    act_off_ff <= {deo_pkg::OFF_RST, deo_pkg::OFF_RST};
                end else begin
                    if (wr_me) begin
                        pend_ff  <= 1'b1;
                        armed_ff <= 1'b0;
                    end else if (LINK.sysref && pend_ff) begin
                        pend_ff  <= 1'b0;
                        armed_ff <= 1'b1;
                    end else if (LINK.link_restart && armed_ff) begin
                        armed_ff <= 1'b0;
                    end
                    if (LINK.link_restart && armed_ff && !wr_me) begin
                        act_off_ff <= nxt_off;
                    end
                end
            end

            // Local multiframe phase, zeroed by SYSREF
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    cnt_ff <= 16'h0000;
                end else if (LINK.sysref) begin
                    cnt_ff <= 16'h0000;
                end else if (last) begin
                    cnt_ff <= 16'h0000;
                end else begin
                    cnt_ff <= cnt_ff + 16'h0001;
                end
            end

            // Release on first boundary after every active lane started
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    rel_ff <= 1'b0;
                end else if (LINK.link_restart) begin
                    rel_ff <= 1'b0;
                end else if (all_seen && bound) begin
                    rel_ff <= 1'b1;
                end
            end
            assign OUT_VALID[d] = rel_ff;
            assign ACTIVE_OFFSET[d*deo_pkg::OFF_W +: deo_pkg::OFF_W] = act_off_ff;

            for (l = 0; l < LANES; l++) begin : g_lane
                localparam int LI = d*LANES + l;
                logic [7:0]         mem [deo_pkg::BUF_OCTETS];
                logic [NW:0]        wptr_ff;
                logic [NW:0]        rptr_ff;
                logic               seen_ff;
                logic [7:0]         dout_ff;
                wire  logic [NW:0]  fill = wptr_ff - rptr_ff;
                wire  logic         full = (fill == FILL_MAX);
                wire  logic         st   = LINK.lane_valid & LINK.lane_mark[LI] & en[l];
                wire  logic         wr   = LINK.lane_valid & (seen_ff | st) & ~full
                                           & ~LINK.link_restart;
                assign seen[l] = seen_ff;

                always_ff @(posedge CLK) begin
                    if (wr) begin
                        mem[wptr_ff[NW-1:0]] <= LINK.lane_data[LI*8 +: 8];
                    end
                end

                // Each lane fills from its own marker: skew lands in depth
                always_ff @(posedge CLK or negedge ARST_N) begin
                    if (!ARST_N) begin
                        wptr_ff <= '0;
                        rptr_ff <= '0;
                        seen_ff <= 1'b0;
                        dout_ff <= 8'h00;
                    end else if (LINK.link_restart) begin
                        wptr_ff <= '0;
                        rptr_ff <= '0;
                        seen_ff <= 1'b0;
                    end else begin
                        if (st) begin
                            seen_ff <= 1'b1;
                        end
                        if (wr) begin
                            wptr_ff <= wptr_ff + 1'b1;
                        end
                        if (rel_ff && fill != '0) begin
                            rptr_ff <= rptr_ff + 1'b1;
                            dout_ff <= mem[rptr_ff[NW-1:0]];
                        end
                    end
                end
                assign OUT_DATA[LI*8 +: 8] = dout_ff;
                assign DEPTH[LI*deo_pkg::PTR_W +: deo_pkg::PTR_W] = fill;
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== deo_framer_host.sv
// Purpose: Framer side controller: programs offsets, pulses SYSREF, restarts, sends lanes
// Assumes: Software writes offsets within 0 to KxS-1
// Notes:   Lane i starts its marker LANE_SKEW*i+1 clocks after restart
`timescale 1ns/10ps
`default_nettype none
module deo_framer_host #(
    parameter int NL        = 4,
    parameter int LANE_SKEW = 3
) (
    // Clock and reset
    input  wire logic          CLK,
    input  wire logic          ARST_N,
    // AXI4-Lite slave
    input  wire logic [3:0]    S_AXI_AWADDR,
    input  wire logic          S_AXI_AWVALID,
    output logic               S_AXI_AWREADY,
    input  wire logic [31:0]   S_AXI_WDATA,
    input  wire logic [3:0]    S_AXI_WSTRB,
    input  wire logic          S_AXI_WVALID,
    output logic               S_AXI_WREADY,
    output logic [1:0]         S_AXI_BRESP,
    output logic               S_AXI_BVALID,
    input  wire logic          S_AXI_BREADY,
    input  wire logic [3:0]    S_AXI_ARADDR,
    input  wire logic          S_AXI_ARVALID,
    output logic               S_AXI_ARREADY,
    output logic [31:0]        S_AXI_RDATA,
    output logic [1:0]         S_AXI_RRESP,
    output logic               S_AXI_RVALID,
    input  wire logic          S_AXI_RREADY,
    // Link
    deo_link_if.host           LINK
);
    typedef enum logic [2:0] {ST_IDLE, ST_WR, ST_SYSREF, ST_RESTART, ST_SEND} deo_st_t;

    deo_st_t     st_ff;
    logic [3:0]  aw_ff;
    logic        aw_ok_ff, w_ok_ff;
    logic [31:0] wd_ff;
    logic [3:0]  ws_ff;
    logic [15:0] off0_ff, off1_ff;
    logic        alt_ff, done_ff;
    logic [2:0]  idx_ff;
    logic [15:0] t_ff;
    logic [31:0] rd_ff;

    wire logic do_wr = aw_ok_ff & w_ok_ff & ~S_AXI_BVALID;
    wire logic go    = do_wr & (aw_ff == deo_pkg::HA_CTRL) & wd_ff[deo_pkg::CTRL_GO]
                       & (st_ff == ST_IDLE || st_ff == ST_SEND);
    wire logic [15:0] off_sel = idx_ff[1] ? off1_ff : off0_ff;
    wire logic [15:0] base    = idx_ff[1] ? (alt_ff ? deo_pkg::RA_D1_ALO : deo_pkg::RA_D1_LO)
                                          : (alt_ff ? deo_pkg::RA_D0_ALO : deo_pkg::RA_D0_LO);
    wire logic [31:0] rd_mux  =
        (S_AXI_ARADDR == deo_pkg::HA_OFF0) ? {16'h0000, off0_ff} :
        (S_AXI_ARADDR == deo_pkg::HA_OFF1) ? {16'h0000, off1_ff} :
        (S_AXI_ARADDR == deo_pkg::HA_STAT) ? {30'h0, done_ff, st_ff != ST_IDLE && !done_ff} :
        (S_AXI_ARADDR == deo_pkg::HA_CTRL) ? {30'h0, alt_ff, 1'b0} : 32'h0000_0000;

    assign S_AXI_AWREADY = ~aw_ok_ff;
    assign S_AXI_WREADY  = ~w_ok_ff;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;
    assign S_AXI_RDATA   = rd_ff;

    // AXI write and read channels
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_ok_ff     <= 1'b0;
            w_ok_ff      <= 1'b0;
            aw_ff        <= 4'h0;
            wd_ff        <= 32'h0000_0000;
            ws_ff        <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= deo_pkg::RESP_OKAY;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RRESP  <= deo_pkg::RESP_OKAY;
            rd_ff        <= 32'h0000_0000;
        end else begin
            if (S_AXI_AWVALID && !aw_ok_ff) begin
                aw_ok_ff <= 1'b1;
                aw_ff    <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && !w_ok_ff) begin
                w_ok_ff <= 1'b1;
                wd_ff   <= S_AXI_WDATA;
                ws_ff   <= S_AXI_WSTRB;
            end
            if (do_wr) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (aw_ff == deo_pkg::HA_STAT) ? deo_pkg::RESP_SLVERR
                                                            : deo_pkg::RESP_OKAY;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                aw_ok_ff     <= 1'b0;
                w_ok_ff      <= 1'b0;
            end
            if (S_AXI_ARVALID && !S_AXI_RVALID) begin
                S_AXI_RVALID <= 1'b1;
                rd_ff        <= rd_mux;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            off0_ff <= 16'h0000;
            off1_ff <= 16'h0000;
            alt_ff  <= 1'b0;
        end else if (do_wr && ws_ff != 4'h0) begin
            if (aw_ff == deo_pkg::HA_OFF0) begin
                off0_ff <= wd_ff[15:0];
            end
            if (aw_ff == deo_pkg::HA_OFF1) begin
                off1_ff <= wd_ff[15:0];
            end
            if (aw_ff == deo_pkg::HA_CTRL) begin
                alt_ff <= wd_ff[deo_pkg::CTRL_ALT];
            end
        end
    end

    // Byte writes, SYSREF, restart, then lane traffic
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_ff   <= ST_IDLE;
            idx_ff  <= 3'h0;
            t_ff    <= 16'h0000;
            done_ff <= 1'b0;
        end else if (go) begin
            st_ff   <= ST_WR;
            idx_ff  <= 3'h0;
            done_ff <= 1'b0;
        end else begin
            unique case (st_ff)
                ST_IDLE:    st_ff <= ST_IDLE;
                ST_WR: begin
                    idx_ff <= idx_ff + 3'h1;
                    if (idx_ff == 3'h3) begin
                        st_ff <= ST_SYSREF;
                    end
                end
                ST_SYSREF:  st_ff <= ST_RESTART;
                ST_RESTART: begin
                    st_ff <= ST_SEND;
                    t_ff  <= 16'h0000;
                end
                ST_SEND: begin
                    t_ff    <= t_ff + 16'h0001;
                    done_ff <= 1'b1;
                end
            endcase
        end
    end

    assign LINK.reg_we       = (st_ff == ST_WR);
    // Idle address is unmapped so the read path returns zero
    assign LINK.reg_addr     = (st_ff == ST_WR) ? base + {15'h0, idx_ff[0]} : 16'h0000;
    assign LINK.reg_wdata    = idx_ff[0] ? off_sel[15:8] : off_sel[7:0];
    assign LINK.sysref       = (st_ff == ST_SYSREF);
    assign LINK.link_restart = (st_ff == ST_RESTART);
    assign LINK.lane_valid   = (st_ff == ST_SEND);

    genvar i;
    generate
        for (i = 0; i < NL; i++) begin : g_tx
            localparam logic [15:0] SK = 16'(LANE_SKEW * i);
            wire logic [15:0] rel = t_ff - SK;
            assign LINK.lane_mark[i]       = (st_ff == ST_SEND) && (t_ff == SK);
            assign LINK.lane_data[i*8 +: 8] = rel[7:0];
        end
    endgenerate
endmodule
`default_nettype wire

// ===== deo_link_chk.sv
// Purpose: Protocol checks on the lane bus and register port between the two ends
// Assumes: Host runs four byte writes, then SYSREF, then restart; lane skew of 3
// Notes:   Sees only the interface signals
`timescale 1ns/10ps
`default_nettype none
module deo_link_chk (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    // Timing and lanes
    input  wire logic        sysref,
    input  wire logic        link_restart,
    input  wire logic        lane_valid,
    input  wire logic [3:0]  lane_mark,
    // Register port
    input  wire logic        reg_we,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_rdata
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    wire logic addr_map = (reg_addr[15:1] == deo_pkg::RA_D0_LO[15:1])
                        || (reg_addr[15:1] == deo_pkg::RA_D1_LO[15:1])
                        || (reg_addr[15:1] == deo_pkg::RA_D0_ALO[15:1])
                        || (reg_addr[15:1] == deo_pkg::RA_D1_ALO[15:1]);

    sequence byte_writes;
        reg_we [*4];
    endsequence
    sequence mark_walk;
        ##1 lane_mark[0] ##3 lane_mark[1] ##3 lane_mark[2] ##3 lane_mark[3];
    endsequence

    a_sysref_single_pulse: assert property (sysref |=> !sysref)
        else $error("sysref held longer than one cycle");
    a_restart_after_sysref: assert property (sysref |=> link_restart)
        else $error("restart did not follow sysref");
    a_sysref_after_write: assert property (sysref |-> $past(reg_we))
        else $error("sysref not right after the offset writes");
    a_four_byte_writes: assert property (
        $rose(reg_we) |-> byte_writes ##1 (!reg_we && sysref))
        else $error("offset write burst malformed");
    a_write_addr_mapped: assert property (reg_we |-> addr_map)
        else $error("write to unmapped address");
    a_low_then_high: assert property (
        reg_we && !reg_addr[0] |=> reg_we && reg_addr == $past(reg_addr) + 16'h0001)
        else $error("high byte did not follow low byte");
    a_unmapped_reads_zero: assert property (!addr_map |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_marks_skewed: assert property (link_restart |-> mark_walk)
        else $error("lane markers out of place");
    a_valid_after_restart: assert property (link_restart |=> lane_valid)
        else $error("lanes idle after restart");
    a_mark_single: assert property (lane_mark[0] |=> !lane_mark[0])
        else $error("lane marker longer than one cycle");
endmodule
`default_nettype wire

// ===== deo_link_if.sv
// Purpose: Lane bus, timing and register port between framer and deframer
// Assumes: Single clock shared by both ends
// Notes:   lane_mark flags the first ILA / multiblock octet of each lane
`timescale 1ns/10ps
`default_nettype none
interface deo_link_if #(
    parameter int NL = 4
);
    logic          sysref;
    logic          link_restart;
    logic          lane_valid;
    logic [NL-1:0] lane_mark;
    logic [NL*8-1:0] lane_data;
    logic          reg_we;
    logic [15:0]   reg_addr;
    logic [7:0]    reg_wdata;
    logic [7:0]    reg_rdata;

    modport dev (
        input  sysref, link_restart, lane_valid, lane_mark, lane_data,
        input  reg_we, reg_addr, reg_wdata,
        output reg_rdata
    );
    modport host (
        output sysref, link_restart, lane_valid, lane_mark, lane_data,
        output reg_we, reg_addr, reg_wdata,
        input  reg_rdata
    );
endinterface
`default_nettype wire

// ===== deo_pkg.sv
// Purpose: Shared constants for the elastic release offset deframer and its framer
// Assumes: One octet per lane per clock on the lane bus
// Notes:   Register port is a byte wide, sixteen bit address
package deo_pkg;
    localparam int          NDFR       = 2;
    localparam int          BUF_OCTETS = 512;
    localparam int          PTR_W      = 10;
    localparam int          OFF_W      = 16;
    localparam logic [15:0] RA_D0_LO   = 16'h6a8e;
    localparam logic [15:0] RA_D0_HI   = 16'h6a8f;
    localparam logic [15:0] RA_D1_LO   = 16'h6c8e;
    localparam logic [15:0] RA_D1_HI   = 16'h6c8f;
    localparam logic [15:0] RA_D0_ALO  = 16'h6a50;
    localparam logic [15:0] RA_D0_AHI  = 16'h6a51;
    localparam logic [15:0] RA_D1_ALO  = 16'h6c50;
    localparam logic [15:0] RA_D1_AHI  = 16'h6c51;
    localparam logic [7:0]  OFF_RST    = 8'h00;
    // Multiframe / extended multiblock length in clocks (K x S)
    localparam logic [15:0] PERIOD_B   = 16'h0020;
    localparam logic [15:0] PERIOD_C   = 16'h0040;
    // Controller register map
    localparam logic [3:0]  HA_CTRL    = 4'h0;
    localparam logic [3:0]  HA_OFF0    = 4'h4;
    localparam logic [3:0]  HA_OFF1    = 4'h8;
    localparam logic [3:0]  HA_STAT    = 4'hc;
    localparam int          CTRL_GO    = 0;
    localparam int          CTRL_ALT   = 1;
    localparam int          STAT_BUSY  = 0;
    localparam int          STAT_DONE  = 1;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ===== tb_top.sv
// Purpose: Drives the framer controller over AXI4-Lite and judges the deframer outputs
// Assumes: Four lanes, two per deframer
// Notes:   Release phase compared between deframers, not absolutely
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk;
    logic        arst_n;
    logic        mode_c;
    logic [3:0]  awaddr;
    logic [3:0]  araddr;
    logic [3:0]  lane_en, wstrb;
    logic [31:0] wdata;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, out_valid;
    logic [31:0] rdata, out_data, act_off;
    logic [39:0] depth;
    int          mismatches, cmp_count, ka, kb;
    int          cyc = 0;

    deo_link_if #(.NL(4)) lnk ();
    deo_framer_host #(.NL(4), .LANE_SKEW(3)) deo_framer_host_i (
        .CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .LINK(lnk.host));
    deo_deframer_dev #(.LANES(2)) deo_deframer_dev_i (
        .CLK(clk), .ARST_N(arst_n), .LINK(lnk.dev), .MODE_C(mode_c), .LANE_EN(lane_en),
        .OUT_VALID(out_valid), .OUT_DATA(out_data), .DEPTH(depth), .ACTIVE_OFFSET(act_off));
    deo_link_chk deo_link_chk_i (
        .CLK(clk), .ARST_N(arst_n), .sysref(lnk.sysref), .link_restart(lnk.link_restart),
        .lane_valid(lnk.lane_valid), .lane_mark(lnk.lane_mark), .reg_we(lnk.reg_we),
        .reg_addr(lnk.reg_addr), .reg_rdata(lnk.reg_rdata));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_p, w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge clk);
            if (awready) aw_p = 1'b0;
            if (wready) w_p = 1'b0;
            awvalid <= aw_p;
            wvalid <= w_p;
        end
        while (!bvalid) @(posedge clk);
        r = bresp;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        d = rdata;
        check("rresp", rresp, deo_pkg::RESP_OKAY);
    endtask

    task automatic test_reset;
        logic [31:0] rd;
        @(posedge clk);
        check("offset after reset", act_off, 32'h0);
        check("release after reset", out_valid, 2'b00);
        axi_rd(deo_pkg::HA_OFF0, rd);
        check("offset reg reset", rd[15:0], 16'h0000);
        $display("reset test done");
    endtask

    task automatic test_refuse;
        logic [1:0]  r;
        logic [31:0] rd;
        axi_wr(deo_pkg::HA_STAT, 32'h0000_0001, r);
        check("status write resp", r, deo_pkg::RESP_SLVERR);
        wstrb <= 4'h0;
        axi_wr(deo_pkg::HA_OFF0, 32'h0000_1234, r);
        wstrb <= 4'hf;
        axi_rd(deo_pkg::HA_OFF0, rd);
        check("strobeless write", rd[15:0], 16'h0000);
        $display("refuse test done");
    endtask

    task automatic t_apply(input logic md, input logic alt, input logic [15:0] o0,
                           input logic [15:0] o1, input logic [1:0] vx, output int k0);
        logic [1:0]  r;
        logic [31:0] rd;
        int          k, k1, p;
        p = md ? int'(deo_pkg::PERIOD_C) : int'(deo_pkg::PERIOD_B);
        mode_c <= md;
        axi_wr(deo_pkg::HA_OFF0, {16'h0000, o0}, r);
        check("bresp", r, deo_pkg::RESP_OKAY);
        axi_wr(deo_pkg::HA_OFF1, {16'h0000, o1}, r);
        axi_rd(deo_pkg::HA_OFF1, rd);
        check("offset readback", rd[15:0], o1);
        axi_wr(deo_pkg::HA_CTRL, {30'h0, alt, 1'b1}, r);
        k = -1;
        k0 = -1;
        k1 = -1;
        // Count cycles from SYSREF to each release
        repeat (300) begin
            @(posedge clk);
            if (lnk.sysref) k = 0;
            else if (k >= 0) k++;
            if (out_valid[0] && k > 2 && k0 < 0) k0 = k;
            if (out_valid[1] && k > 2 && k1 < 0) k1 = k;
        end
        check("active offset", act_off, {o1, o0});
        check("released", {k1 > 0, k0 > 0}, vx);
        if (vx == 2'b11) begin
            check("phase", (k0 - o0 + 8 * p) % p, (k1 - o1 + 8 * p) % p);
        end
        if (vx[0] && lane_en[1]) begin
            check("skew d0", 10'(depth[9:0] - depth[19:10]), 32'h3);
            check("aligned d0", out_data[7:0], out_data[15:8]);
        end
        if (!lane_en[1]) begin
            check("idle lane depth", depth[19:10], 32'h0);
        end
        if (vx[1]) begin
            check("skew d1", 10'(depth[29:20] - depth[39:30]), 32'h3);
            check("aligned d1", out_data[23:16], out_data[31:24]);
        end
        axi_rd(deo_pkg::HA_STAT, rd);
        check("status", rd[1:0], 2'b10);
        $display("apply test done");
    endtask

    // Lane 1 off: deframer 0 waits on lane 0 only, so it releases in the first multiframe
    task automatic test_lane_off;
        int k;
        lane_en <= 4'b1101;
        t_apply(1'b0, 1'b0, 16'h0002, 16'h001f, 2'b11, k);
        check("early release", k < int'(deo_pkg::PERIOD_B), 1'b1);
        lane_en <= 4'hf;
        $display("lane off test done");
    endtask

    // Full reset mid-run stands for reprogramming the whole device
    task automatic test_reprogram;
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check("offset in reset", act_off, 32'h0);
        check("release in reset", out_valid, 2'b00);
        arst_n <= 1'b1;
        test_reset;
        $display("reprogram test done");
    endtask

    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            complete_run;
        end
    end

    initial begin
        arst_n = 1'b0;
        mode_c = 1'b0;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        bready = 1'b1;
        rready = 1'b1;
        lane_en = 4'hf;
        wstrb = 4'hf;
        mismatches = 0;
        cmp_count = 0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        test_reset;
        test_refuse;
        t_apply(1'b0, 1'b0, 16'h0005, 16'h001f, 2'b11, ka);
        t_apply(1'b0, 1'b1, 16'h0005, 16'h001f, 2'b11, kb);
        check("repeat latency", kb, ka);
        test_lane_off;
        test_reprogram;
        t_apply(1'b1, 1'b1, 16'h0020, 16'h0040, 2'b01, kb);
        t_apply(1'b1, 1'b0, 16'h003f, 16'h0000, 2'b11, kb);
        complete_run;
    end
endmodule
`default_nettype wire
